// file: hdl/ace_consts.svh
// register map, field positions, reset values and protocol codes of the entry matcher
`ifndef ACE_CONSTS_SVH
`define ACE_CONSTS_SVH

`define ACE_ADDR_W 8
`define ACE_OFF_CTRL 8'h00
`define ACE_OFF_VALUE 8'h04
`define ACE_OFF_SRC_ADDR 8'h08
`define ACE_OFF_SRC_MASK 8'h0c
`define ACE_OFF_HIT_COUNT 8'h10
`define ACE_OFF_FRAME_COUNT 8'h14

`define ACE_CTRL_EN 0
`define ACE_CTRL_NH_LSB 1
`define ACE_CTRL_NH_MSB 3
`define ACE_CTRL_SRC 4
`define ACE_CTRL_HOP_LSB 5
`define ACE_CTRL_HOP_MSB 6
`define ACE_CTRL_TYPE 7
`define ACE_CTRL_CODE 8
`define ACE_CTRL_MASK 32'h0000_01ff

`define ACE_VAL_NH_LSB 0
`define ACE_VAL_NH_MSB 7
`define ACE_VAL_TYPE_LSB 8
`define ACE_VAL_TYPE_MSB 15
`define ACE_VAL_CODE_LSB 16
`define ACE_VAL_CODE_MSB 23
`define ACE_VAL_MASK 32'h00ff_ffff

`define ACE_CTRL_RST 32'h0000_0000
`define ACE_VALUE_RST 32'h0000_0000
`define ACE_SRC_ADDR_RST 32'h0000_0000
`define ACE_SRC_MASK_RST 32'hffff_ffff
`define ACE_UNMAPPED_RDAT 32'h0000_0000

`define ACE_PROTO_ICMP6 8'h3a
`define ACE_PROTO_UDP 8'h11
`define ACE_PROTO_TCP 8'h06

`endif

// file: hdl/ace_pkg.sv
// mode types of the entry matcher
package ace_pkg;
  typedef enum logic [2:0] {NH_ANY, NH_SPECIFIC, NH_ICMP, NH_UDP, NH_TCP} nh_mode_t;
  typedef enum logic [1:0] {HOP_ANY, HOP_ZERO, HOP_NONZERO} hop_mode_t;
endpackage : ace_pkg

// file: hdl/ace_field_match.sv
// combinational comparison of one frame's header fields against the entry settings
`include "ace_consts.svh"

module ace_field_match
(
  // entry settings
  input wire logic [2:0] nh_mode,
  input wire logic [7:0] nh_value,
  input wire logic src_specific,
  input wire logic [31:0] src_addr,
  input wire logic [31:0] src_mask,
  input wire logic [1:0] hop_mode,
  input wire logic type_specific,
  input wire logic [7:0] type_value,
  input wire logic code_specific,
  input wire logic [7:0] code_value,
  // frame fields
  input wire logic is_ipv6,
  input wire logic [7:0] next_hdr,
  input wire logic [31:0] src_low,
  input wire logic [7:0] hop_limit,
  input wire logic [7:0] icmp_type,
  input wire logic [7:0] icmp_code,
  // result
  output logic match
);
  ace_pkg::nh_mode_t nh_sel;
  ace_pkg::hop_mode_t hop_sel;
  logic nh_ok;
  logic hop_ok;
  wire is_icmp = next_hdr == `ACE_PROTO_ICMP6;
  // RQ6: mask zeros are don't-care
  wire src_eq = (src_low & src_mask) == (src_addr & src_mask);
  // RQ4: any source passes
  // RQ5: only low 32 address bits compared
  wire src_ok = !src_specific || src_eq;
  // RQ10: type ignored when any
  // RQ11: type compared when specific
  wire type_ok = !type_specific || icmp_type == type_value;
  // RQ12: code ignored when any
  // RQ13: code compared when specific
  wire code_ok = !code_specific || icmp_code == code_value;

  assign nh_sel = ace_pkg::nh_mode_t'(nh_mode);
  assign hop_sel = ace_pkg::hop_mode_t'(hop_mode);

  always_comb
  begin
    unique case (nh_sel)
      // RQ1: next header ignored
      ace_pkg::NH_ANY: nh_ok = 1'b1;
      // RQ2: exact next header value
      ace_pkg::NH_SPECIFIC: nh_ok = next_hdr == nh_value;
      // RQ3: protocol selection plus parameters
      // RQ15: icmp fields only for icmp frames
      ace_pkg::NH_ICMP: nh_ok = is_icmp && type_ok && code_ok;
      ace_pkg::NH_UDP: nh_ok = next_hdr == `ACE_PROTO_UDP;
      ace_pkg::NH_TCP: nh_ok = next_hdr == `ACE_PROTO_TCP;
      // unused codes never match, so a stray write cannot open the entry
      default: nh_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    unique case (hop_sel)
      // RQ9: hop limit ignored
      ace_pkg::HOP_ANY: hop_ok = 1'b1;
      // RQ7: nonzero hop limit excluded
      ace_pkg::HOP_ZERO: hop_ok = hop_limit == 8'h00;
      // RQ8: nonzero hop limit allowed
      ace_pkg::HOP_NONZERO: hop_ok = hop_limit != 8'h00;
      default: hop_ok = 1'b0;
    endcase
  end

  // RQ14: every filter must agree
  assign match = is_ipv6 && nh_ok && src_ok && hop_ok;
endmodule : ace_field_match

// file: hdl/ipv6_icmp_access_entry_match.sv
// one ipv6/icmp access control entry with its wishbone register file
//
// Local design decisions: the Wishbone register port and the register addresses.
`include "ace_consts.svh"

// Operation
// RQ1: next header any ignores the field
// RQ2: specific next header must equal value
// RQ3: icmp/udp/tcp selects protocol, applies parameters
// RQ4: source any ignores source address
// RQ5: specific source compares low 32 bits
// RQ6: mask zero bits are don't-care
// RQ7: hop zero excludes nonzero hop limits
// RQ8: hop nonzero admits nonzero hop limits
// RQ9: hop any ignores hop limit
// RQ10: icmp type any ignores type
// RQ11: specific icmp type must equal value
// RQ12: icmp code any ignores code
// RQ13: specific icmp code must equal value
// RQ14: hit only when all filters pass
// RQ15: icmp fields apply only to icmp frames
module ipv6_icmp_access_entry_match
#(
  parameter int CNT_W = 32
)
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [`ACE_ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // frame fields from the parser
  input wire logic FRAME_VALID,
  input wire logic FRAME_IS_IPV6,
  input wire logic [7:0] FRAME_NEXT_HDR,
  input wire logic [31:0] FRAME_SRC_LOW,
  input wire logic [7:0] FRAME_HOP_LIMIT,
  input wire logic [7:0] FRAME_ICMP_TYPE,
  input wire logic [7:0] FRAME_ICMP_CODE,
  // match result
  output logic HIT_VALID,
  output logic HIT
);
  logic [31:0] ctrl;
  logic [31:0] value;
  logic [31:0] source_ip_address;
  logic [31:0] source_ip_match_mask;
  logic [CNT_W-1:0] hit_count;
  logic [CNT_W-1:0] frame_count;
  logic core_match;
  logic ack;
  logic [31:0] rdat;

  function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : apply_sel

  // bus decode
  wire access = WB_CYC_I && WB_STB_I && !ack;
  wire wr = access && WB_WE_I;
  wire sel_ctrl = WB_ADR_I == `ACE_OFF_CTRL;
  wire sel_value = WB_ADR_I == `ACE_OFF_VALUE;
  wire sel_saddr = WB_ADR_I == `ACE_OFF_SRC_ADDR;
  wire sel_smask = WB_ADR_I == `ACE_OFF_SRC_MASK;
  wire sel_hits = WB_ADR_I == `ACE_OFF_HIT_COUNT;
  wire sel_frames = WB_ADR_I == `ACE_OFF_FRAME_COUNT;
  wire [31:0] next_ctrl = apply_sel(ctrl, WB_DAT_I, WB_SEL_I) & `ACE_CTRL_MASK;
  wire [31:0] next_value = apply_sel(value, WB_DAT_I, WB_SEL_I) & `ACE_VAL_MASK;
  wire [31:0] next_saddr = apply_sel(source_ip_address, WB_DAT_I, WB_SEL_I);
  wire [31:0] next_smask = apply_sel(source_ip_match_mask, WB_DAT_I, WB_SEL_I);
  wire [31:0] next_rdat =
    sel_ctrl ? ctrl :
    sel_value ? value :
    sel_saddr ? source_ip_address :
    sel_smask ? source_ip_match_mask :
    sel_hits ? 32'(hit_count) :
    sel_frames ? 32'(frame_count) :
    `ACE_UNMAPPED_RDAT;

  // settings fields
  wire entry_en = ctrl[`ACE_CTRL_EN];
  wire [2:0] nh_mode = ctrl[`ACE_CTRL_NH_MSB:`ACE_CTRL_NH_LSB];
  wire src_specific = ctrl[`ACE_CTRL_SRC];
  wire [1:0] hop_mode = ctrl[`ACE_CTRL_HOP_MSB:`ACE_CTRL_HOP_LSB];
  wire type_specific = ctrl[`ACE_CTRL_TYPE];
  wire code_specific = ctrl[`ACE_CTRL_CODE];
  wire [7:0] nh_value = value[`ACE_VAL_NH_MSB:`ACE_VAL_NH_LSB];
  wire [7:0] type_value = value[`ACE_VAL_TYPE_MSB:`ACE_VAL_TYPE_LSB];
  wire [7:0] code_value = value[`ACE_VAL_CODE_MSB:`ACE_VAL_CODE_LSB];

  ace_field_match ace_field_match_inst
  (
    .nh_mode(nh_mode),
    .nh_value(nh_value),
    .src_specific(src_specific),
    .src_addr(source_ip_address),
    .src_mask(source_ip_match_mask),
    .hop_mode(hop_mode),
    .type_specific(type_specific),
    .type_value(type_value),
    .code_specific(code_specific),
    .code_value(code_value),
    .is_ipv6(FRAME_IS_IPV6),
    .next_hdr(FRAME_NEXT_HDR),
    .src_low(FRAME_SRC_LOW),
    .hop_limit(FRAME_HOP_LIMIT),
    .icmp_type(FRAME_ICMP_TYPE),
    .icmp_code(FRAME_ICMP_CODE),
    .match(core_match)
  );

  // RQ14: disabled entry never hits
  wire next_hit = FRAME_VALID && entry_en && core_match;
  wire hit_clr = wr && sel_hits;
  wire frame_clr = wr && sel_frames;
  wire [CNT_W-1:0] cnt_one = {{(CNT_W-1){1'b0}}, 1'b1};

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      ack <= 1'b0;
      rdat <= `ACE_UNMAPPED_RDAT;
    end
    else
    begin
      ack <= access;
      if (access)
        rdat <= next_rdat;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      ctrl <= `ACE_CTRL_RST;
      value <= `ACE_VALUE_RST;
      source_ip_address <= `ACE_SRC_ADDR_RST;
      source_ip_match_mask <= `ACE_SRC_MASK_RST;
    end
    else
    begin
      if (wr && sel_ctrl)
        ctrl <= next_ctrl;
      if (wr && sel_value)
        value <= next_value;
      if (wr && sel_saddr)
        source_ip_address <= next_saddr;
      if (wr && sel_smask)
        source_ip_match_mask <= next_smask;
    end
  end

  // a count arriving with the clearing write survives as one
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      hit_count <= '0;
      frame_count <= '0;
    end
    else
    begin
      if (hit_clr)
        hit_count <= next_hit ? cnt_one : '0;
      else if (next_hit)
        hit_count <= hit_count + cnt_one;
      if (frame_clr)
        frame_count <= FRAME_VALID ? cnt_one : '0;
      else if (FRAME_VALID)
        frame_count <= frame_count + cnt_one;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      HIT_VALID <= 1'b0;
      HIT <= 1'b0;
    end
    else
    begin
      HIT_VALID <= FRAME_VALID;
      HIT <= next_hit;
    end
  end

  assign WB_ACK_O = ack;
  assign WB_DAT_O = rdat;

  // shared condition: entry on, ipv6 frame presented
  wire live = FRAME_VALID && entry_en && FRAME_IS_IPV6;

  any_pass_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ1 RQ4 RQ9
    live && nh_mode == 3'(ace_pkg::NH_ANY) && !src_specific
      && hop_mode == 2'(ace_pkg::HOP_ANY) |=> HIT_VALID && HIT)
    else $error("all-any entry missed an ipv6 frame");

  nh_value_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ2
    FRAME_VALID && nh_mode == 3'(ace_pkg::NH_SPECIFIC) && FRAME_NEXT_HDR != nh_value
      |=> HIT_VALID && !HIT)
    else $error("hit despite next header mismatch");

  nh_proto_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ3
    FRAME_VALID && nh_mode == 3'(ace_pkg::NH_TCP) && FRAME_NEXT_HDR != `ACE_PROTO_TCP
      |=> !HIT)
    else $error("tcp entry hit a non-tcp frame");

  src_mask_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ5 RQ6
    FRAME_VALID && src_specific
      && ((FRAME_SRC_LOW ^ source_ip_address) & source_ip_match_mask) != 32'h0000_0000
      |=> !HIT)
    else $error("hit despite masked source mismatch");

  hop_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ7
    FRAME_VALID && hop_mode == 2'(ace_pkg::HOP_ZERO) && FRAME_HOP_LIMIT != 8'h00
      |=> !HIT)
    else $error("zero hop entry hit nonzero hop limit");

  hop_nonzero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ8
    live && nh_mode == 3'(ace_pkg::NH_ANY) && !src_specific
      && hop_mode == 2'(ace_pkg::HOP_NONZERO) && FRAME_HOP_LIMIT != 8'h00 |=> HIT)
    else $error("nonzero hop entry missed a frame");

  icmp_any_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ10 RQ12 RQ15
    live && nh_mode == 3'(ace_pkg::NH_ICMP) && FRAME_NEXT_HDR == `ACE_PROTO_ICMP6
      && !type_specific && !code_specific && !src_specific
      && hop_mode == 2'(ace_pkg::HOP_ANY) |=> HIT)
    else $error("icmp entry with any type and code missed");

  icmp_type_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ11
    FRAME_VALID && nh_mode == 3'(ace_pkg::NH_ICMP) && type_specific
      && FRAME_ICMP_TYPE != type_value |=> !HIT)
    else $error("hit despite icmp type mismatch");

  icmp_code_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ13
    FRAME_VALID && nh_mode == 3'(ace_pkg::NH_ICMP) && code_specific
      && FRAME_ICMP_CODE != code_value |=> !HIT)
    else $error("hit despite icmp code mismatch");

  hit_count_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ14
    HIT && !$past(hit_clr) |-> hit_count == $past(hit_count) + cnt_one)
    else $error("hit counter did not follow a hit");

  ack_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    WB_CYC_I && WB_STB_I && !ack |=> ack ##1 !ack)
    else $error("wishbone ack not a single cycle");

  // reserved codes must close the entry, never open it
  nh_reserved_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ14
    FRAME_VALID && nh_mode > 3'(ace_pkg::NH_TCP) |=> HIT_VALID && !HIT)
    else $error("reserved next header mode produced a hit");

  hop_reserved_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ14
    FRAME_VALID && hop_mode > 2'(ace_pkg::HOP_NONZERO) |=> HIT_VALID && !HIT)
    else $error("reserved hop mode produced a hit");

  entry_off_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ14
    FRAME_VALID && !entry_en |=> HIT_VALID && !HIT)
    else $error("disabled entry produced a hit");

  not_ipv6_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ14
    FRAME_VALID && !FRAME_IS_IPV6 |=> HIT_VALID && !HIT)
    else $error("non-ipv6 frame produced a hit");

  icmp_other_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ15
    FRAME_VALID && nh_mode == 3'(ace_pkg::NH_ICMP) && FRAME_NEXT_HDR != `ACE_PROTO_ICMP6
      |=> !HIT)
    else $error("icmp entry hit a non-icmp frame");

  udp_proto_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ3
    FRAME_VALID && nh_mode == 3'(ace_pkg::NH_UDP) && FRAME_NEXT_HDR != `ACE_PROTO_UDP
      |=> !HIT)
    else $error("udp entry hit a non-udp frame");

  result_idle_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ14
    !FRAME_VALID |=> !HIT_VALID && !HIT)
    else $error("result shown without a frame");

  // counters and read data seen by software
  frame_count_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    HIT_VALID && !$past(frame_clr) |-> frame_count == $past(frame_count) + cnt_one)
    else $error("frame counter did not follow a frame");

  count_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    hit_clr && !next_hit |=> hit_count == '0)
    else $error("hit counter not cleared by a write");

  read_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !access |=> $stable(WB_DAT_O))
    else $error("read data changed without an access");
endmodule : ipv6_icmp_access_entry_match

// file: tb/frame_source.sv
// parser-side model that presents one frame's header fields per call
module frame_source
(
  // clock
  input wire logic clk,
  // frame fields
  output logic valid,
  output logic is_ipv6,
  output logic [7:0] next_hdr,
  output logic [31:0] src_low,
  output logic [7:0] hop,
  output logic [7:0] icmp_type,
  output logic [7:0] icmp_code
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    valid = 1'b0;
    is_ipv6 = 1'b0;
    next_hdr = 8'h00;
    src_low = 32'h0000_0000;
    hop = 8'h00;
    icmp_type = 8'h00;
    icmp_code = 8'h00;
  end

  // fields are inverted once the pulse ends, so a stale value can never pass
  task automatic send(input logic v6, input logic [7:0] nh, input logic [31:0] src,
                      input logic [7:0] hl, input logic [7:0] ty, input logic [7:0] cd);
    valid <= 1'b1;
    is_ipv6 <= v6;
    next_hdr <= nh;
    src_low <= src;
    hop <= hl;
    icmp_type <= ty;
    icmp_code <= cd;
    @(posedge clk);
    valid <= 1'b0;
    is_ipv6 <= ~v6;
    next_hdr <= ~nh;
    src_low <= ~src;
    hop <= ~hl;
    icmp_type <= ~ty;
    icmp_code <= ~cd;
  endtask : send
endmodule : frame_source

// file: tb/ipv6_icmp_access_entry_match_tb.sv
// self-checking bench of the entry matcher over wishbone and frame pulses
`include "ace_consts.svh"
module ipv6_icmp_access_entry_match_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, HIT_VALID, HIT;
  logic [7:0] WB_ADR_I;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O;
  logic FRAME_VALID, FRAME_IS_IPV6;
  logic [7:0] FRAME_NEXT_HDR, FRAME_HOP_LIMIT, FRAME_ICMP_TYPE, FRAME_ICMP_CODE;
  logic [31:0] FRAME_SRC_LOW;
  int fail_count = 0;
  int check_count = 0;
  int frames = 0;
  int hits = 0;
  logic [31:0] md [3] = '{32'h005, 32'h007, 32'h009};
  logic [7:0] pr [3] = '{`ACE_PROTO_ICMP6, `ACE_PROTO_UDP, `ACE_PROTO_TCP};

  ipv6_icmp_access_entry_match ipv6_icmp_access_entry_match_inst (.CLK_SYS, .RST_N,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O,
    .FRAME_VALID, .FRAME_IS_IPV6, .FRAME_NEXT_HDR, .FRAME_SRC_LOW, .FRAME_HOP_LIMIT,
    .FRAME_ICMP_TYPE, .FRAME_ICMP_CODE, .HIT_VALID, .HIT);
  frame_source frame_source_inst (.clk(CLK_SYS), .valid(FRAME_VALID), .is_ipv6(FRAME_IS_IPV6),
    .next_hdr(FRAME_NEXT_HDR), .src_low(FRAME_SRC_LOW), .hop(FRAME_HOP_LIMIT),
    .icmp_type(FRAME_ICMP_TYPE), .icmp_code(FRAME_ICMP_CODE));

  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk

  // ack is sampled at the edge, then one idle cycle before the next access
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_SEL_I <= s;
    WB_DAT_I <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge CLK_SYS);
      if (WB_ACK_O === 1'b1)
        break;
    end
    if (n == 20)
    begin
      fail_count++;
      give_verdict();
    end
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK_SYS);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wrs(a, d, 4'hf);
  endtask : wr

  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask : wrs

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask : rd

  task automatic cfg(input logic [31:0] ctrl, input logic [31:0] val);
    wr(`ACE_OFF_CTRL, ctrl);
    wr(`ACE_OFF_VALUE, val);
  endtask : cfg

  task automatic fr(input logic v6, input logic [7:0] nh, input logic [31:0] src,
                    input logic [7:0] hl, input logic [7:0] ty, input logic [7:0] cd,
                    input logic exp);
    frame_source_inst.send(v6, nh, src, hl, ty, cd);
    #1;
    chk({31'h0, HIT_VALID}, 32'h1);
    chk({31'h0, HIT}, {31'h0, exp});
    frames++;
    hits += int'(exp);
    @(posedge CLK_SYS);
    #1;
    // result must last one cycle only
    chk({30'h0, HIT_VALID, HIT}, 32'h0);
    @(posedge CLK_SYS);
  endtask : fr

  initial
  begin
    RST_N = 1'b0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} = '0;
    WB_SEL_I = 4'hf;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    rd(`ACE_OFF_CTRL, `ACE_CTRL_RST);
    rd(`ACE_OFF_SRC_MASK, `ACE_SRC_MASK_RST);
    rd(8'h18, `ACE_UNMAPPED_RDAT);
    fr(1'b1, 8'h11, 32'h0, 8'h05, 8'h00, 8'h00, 1'b0);
    $display("test reset done");
    cfg(32'h001, 32'h0);
    fr(1'b1, 8'h11, 32'h1234, 8'h05, 8'h07, 8'h09, 1'b1);
    cfg(32'h003, 32'h0ff);
    fr(1'b1, 8'hff, 32'h0, 8'h05, 8'h00, 8'h00, 1'b1);
    fr(1'b1, 8'hfe, 32'h0, 8'h05, 8'h00, 8'h00, 1'b0);
    fr(1'b0, 8'hff, 32'h0, 8'h05, 8'h00, 8'h00, 1'b0);
    cfg(32'h00b, 32'h0);
    fr(1'b1, 8'h11, 32'h0, 8'h05, 8'h00, 8'h00, 1'b0);
    cfg(32'h061, 32'h0);
    fr(1'b1, 8'h11, 32'h0, 8'h05, 8'h00, 8'h00, 1'b0);
    cfg(32'h001, 32'h0);
    fr(1'b0, 8'h11, 32'h0, 8'h05, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      cfg(md[i], 32'h0);
      for (int j = 0; j < 3; j++)
        fr(1'b1, pr[j], 32'h0, 8'h01, 8'h55, 8'h66, i == j);
    end
    $display("test next header done");
    wr(`ACE_OFF_SRC_ADDR, 32'h2001_0003);
    wr(`ACE_OFF_SRC_MASK, 32'hffff_fffe);
    cfg(32'h011, 32'h0);
    fr(1'b1, 8'h11, 32'h2001_0002, 8'h05, 8'h00, 8'h00, 1'b1);
    fr(1'b1, 8'h11, 32'h2001_0003, 8'h05, 8'h00, 8'h00, 1'b1);
    fr(1'b1, 8'h11, 32'h2001_0001, 8'h05, 8'h00, 8'h00, 1'b0);
    fr(1'b1, 8'h11, 32'ha001_0003, 8'h05, 8'h00, 8'h00, 1'b0);
    $display("test source done");
    cfg(32'h021, 32'h0);
    fr(1'b1, 8'h11, 32'h0, 8'h00, 8'h00, 8'h00, 1'b1);
    fr(1'b1, 8'h11, 32'h0, 8'h01, 8'h00, 8'h00, 1'b0);
    cfg(32'h041, 32'h0);
    fr(1'b1, 8'h11, 32'h0, 8'hff, 8'h00, 8'h00, 1'b1);
    fr(1'b1, 8'h11, 32'h0, 8'h00, 8'h00, 8'h00, 1'b0);
    cfg(32'h025, 32'h0);
    fr(1'b1, 8'h3a, 32'h0, 8'h00, 8'h00, 8'h00, 1'b1);
    fr(1'b1, 8'h3a, 32'h0, 8'h03, 8'h00, 8'h00, 1'b0);
    $display("test hop limit done");
    cfg(32'h085, 32'h00_8000);
    fr(1'b1, 8'h3a, 32'h0, 8'h05, 8'h80, 8'h33, 1'b1);
    fr(1'b1, 8'h3a, 32'h0, 8'h05, 8'h81, 8'h33, 1'b0);
    cfg(32'h185, 32'hff_8000);
    fr(1'b1, 8'h3a, 32'h0, 8'h05, 8'h80, 8'hff, 1'b1);
    fr(1'b1, 8'h3a, 32'h0, 8'h05, 8'h80, 8'hfe, 1'b0);
    fr(1'b1, 8'h11, 32'h0, 8'h05, 8'h80, 8'hff, 1'b0);
    $display("test icmp done");
    rd(`ACE_OFF_HIT_COUNT, 32'(hits));
    rd(`ACE_OFF_FRAME_COUNT, 32'(frames));
    wr(`ACE_OFF_FRAME_COUNT, 32'h0);
    rd(`ACE_OFF_FRAME_COUNT, 32'h0);
    $display("test counters done");
    wrs(`ACE_OFF_SRC_ADDR, 32'hffff_ffff, 4'h2);
    rd(`ACE_OFF_SRC_ADDR, 32'h2001_ff03);
    wr(`ACE_OFF_VALUE, 32'hffff_ffff);
    rd(`ACE_OFF_VALUE, `ACE_VAL_MASK);
    wr(`ACE_OFF_HIT_COUNT, 32'h0);
    rd(`ACE_OFF_HIT_COUNT, 32'h0);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, `ACE_UNMAPPED_RDAT);
    $display("test registers done");
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    rd(`ACE_OFF_SRC_ADDR, `ACE_SRC_ADDR_RST);
    rd(`ACE_OFF_SRC_MASK, `ACE_SRC_MASK_RST);
    rd(`ACE_OFF_CTRL, `ACE_CTRL_RST);
    rd(`ACE_OFF_FRAME_COUNT, 32'h0);
    fr(1'b1, 8'h11, 32'h0, 8'h05, 8'h00, 8'h00, 1'b0);
    $display("test second reset done");
    give_verdict();
  end
endmodule : ipv6_icmp_access_entry_match_tb
